// *** src/pevu_pkg.sv ***
/*
 * Package for the processor event unit: register offsets, field layout,
 * reset values and the bus/channel carriers.
 * Assumes a 32-bit word-addressed register port with byte offsets.
 */
package pevu_pkg;
    localparam int NUM_TASKS = 8;
    localparam int NUM_CHAN = 8;
    localparam int ICX_W = 8;
    localparam int ADDR_W = 12;

    localparam logic [11:0] OFS_SEND_TRIG = 12'h000;
    localparam logic [11:0] OFS_SEND_HOOK = 12'h080;
    localparam logic [11:0] OFS_RECV_FLAG = 12'h100;
    localparam logic [11:0] OFS_RECV_FWD = 12'h180;
    localparam logic [11:0] OFS_IRQ_EN = 12'h300;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_IRQ_PEND = 12'h30C;
    localparam logic [11:0] OFS_SEND_MAP = 12'h510;
    localparam logic [11:0] OFS_RECV_MAP = 12'h590;
    localparam logic [11:0] OFS_SCRATCH = 12'h610;

    localparam int HOOK_EN_BIT = 31;
    localparam int HOOK_IDX_LSB = 0;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pevu_req_t;

    typedef struct packed {
        logic [NUM_CHAN-1:0] pulse;
    } pevu_chan_t;

    typedef struct packed {
        logic en;
        logic [ICX_W-1:0] idx;
    } pevu_hook_t;
endpackage

// *** src/pevu_top.sv ***
/*
 * Processor event unit: eight send tasks broadcast onto shared channels,
 * eight receive events listen on subscribed channels, with interconnect
 * hookup, interrupt enable/set/clear/pending and four scratch words.
 * Assumes peer units OR their channel pulses together outside, and an
 * interconnect bus of one-cycle pulses, one bit per channel index.
 */
// The strobed register port is this design's own decision.
// Functional notes
// RULE_01: Send task pulses exactly its mapped channels
// RULE_02: Maps accept any channel combination
// RULE_03: Receive event fires on subscribed pulse
// RULE_04: Coincident channel pulses raise event once
// RULE_05: One instance per processor
// RULE_06: Send triggers at 0x000, stride four
// RULE_07: Send maps at 0x510, reset zero
// RULE_08: Receive maps at 0x590, reset zero
// RULE_09: Receive flags at 0x100 set on event
// RULE_10: Subscribe registers at 0x080 trigger sends
// RULE_11: Publish registers at 0x180 forward events
// RULE_12: Interrupt enable at 0x300, bits 0-7
// RULE_13: Enable-set writes one to enable
// RULE_14: Enable-clear writes one to disable
// RULE_15: Pending reads flagged and enabled events
// RULE_16: Subscribe has index and enable bit
// RULE_17: Flag reads one once generated, resets zero
// RULE_18: Software clears flag by writing zero
// RULE_19: Four scratch words, no side effects
`timescale 1ns/1ps
`default_nettype none
module pevu_top
    import pevu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [pevu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Shared channels (OR of all peer units)
    input wire pevu_pkg::pevu_chan_t chan_in,
    output pevu_pkg::pevu_chan_t chan_out,
    // Task/event interconnect
    input wire logic [(1<<pevu_pkg::ICX_W)-1:0] icx_in,
    output logic [(1<<pevu_pkg::ICX_W)-1:0] icx_out,
    // Interrupt
    output logic irq
);
    import pevu_pkg::*;

    localparam int NW = 1 << ICX_W;

    pevu_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                   rd: reg_rd};

    // Hit flag in bit 3 and slot in bits 2:0; all zero on a miss
    function automatic logic [3:0] grp_hit(input logic [11:0] a,
                                           input logic [11:0] base,
                                           input logic [3:0] cnt);
        logic [11:0] d;
        d = a - base;
        if (a >= base && d[1:0] == 2'b00 && d[11:2] < {6'h00, cnt})
            grp_hit = {1'b1, d[4:2]};
        else
            grp_hit = 4'h0;
    endfunction

    function automatic logic [31:0] hook_word(input pevu_hook_t h);
        hook_word = RST_WORD;
        hook_word[HOOK_EN_BIT] = h.en;
        hook_word[HOOK_IDX_LSB +: ICX_W] = h.idx;
    endfunction

    logic [7:0] send_map_q [NUM_TASKS];
    logic [7:0] send_map_d [NUM_TASKS];
    logic [7:0] recv_map_q [NUM_TASKS];
    logic [7:0] recv_map_d [NUM_TASKS];
    pevu_hook_t hook_q [NUM_TASKS];
    pevu_hook_t hook_d [NUM_TASKS];
    pevu_hook_t fwd_q [NUM_TASKS];
    pevu_hook_t fwd_d [NUM_TASKS];
    logic [31:0] scr_q [4];
    logic [31:0] scr_d [4];
    logic [7:0] flag_q, flag_d;
    logic [7:0] irq_enable_q, irq_enable_d;
    logic [7:0] recv_ev;
    logic [7:0] fire;
    logic [NUM_CHAN-1:0] chan_d;
    logic [NW-1:0] icx_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic irq_d;
    logic irq_q;
    pevu_chan_t chan_q;
    logic [NW-1:0] icx_q;
    logic [3:0] h_trig, h_hook, h_flag, h_fwd, h_smap, h_rmap, h_scr;

    assign h_trig = grp_hit(req.addr, OFS_SEND_TRIG, 4'h8);
    assign h_hook = grp_hit(req.addr, OFS_SEND_HOOK, 4'h8);
    assign h_flag = grp_hit(req.addr, OFS_RECV_FLAG, 4'h8);
    assign h_fwd = grp_hit(req.addr, OFS_RECV_FWD, 4'h8);
    assign h_smap = grp_hit(req.addr, OFS_SEND_MAP, 4'h8);
    assign h_rmap = grp_hit(req.addr, OFS_RECV_MAP, 4'h8);
    assign h_scr = grp_hit(req.addr, OFS_SCRATCH, 4'h4);

    // Event logic: tasks, channels, receive events
    always_comb begin
        fire = '0;
        chan_d = '0;
        icx_d = '0;
        recv_ev = '0;
        for (int n = 0; n < NUM_TASKS; n++) begin
            // RULE_06: register trigger of task n
            if (req.wr && h_trig[3] && h_trig[2:0] == 3'(n) && req.wdata[0])
                fire[n] = 1'b1;
            // RULE_10 RULE_16: interconnect subscription
            if (hook_q[n].en && icx_in[hook_q[n].idx])
                fire[n] = 1'b1;
            // RULE_01 RULE_02: broadcast on mapped channels only
            if (fire[n])
                chan_d = chan_d | send_map_q[n];
        end
        for (int n = 0; n < NUM_TASKS; n++) begin
            // RULE_03 RULE_04: any subscribed pulse, counted once
            recv_ev[n] = |(chan_in.pulse & recv_map_q[n]);
            // RULE_11: forward event onto interconnect
            if (recv_ev[n] && fwd_q[n].en)
                icx_d[fwd_q[n].idx] = 1'b1;
        end
    end

    // Configuration and flag next state
    always_comb begin
        send_map_d = send_map_q;
        recv_map_d = recv_map_q;
        hook_d = hook_q;
        fwd_d = fwd_q;
        scr_d = scr_q;
        flag_d = flag_q;
        irq_enable_d = irq_enable_q;
        if (req.wr) begin
            // RULE_07: send channel map write
            if (h_smap[3])
                send_map_d[h_smap[2:0]] = req.wdata[7:0];
            // RULE_08: receive channel map write
            if (h_rmap[3])
                recv_map_d[h_rmap[2:0]] = req.wdata[7:0];
            if (h_hook[3]) begin
                hook_d[h_hook[2:0]].en = req.wdata[HOOK_EN_BIT];
                hook_d[h_hook[2:0]].idx = req.wdata[HOOK_IDX_LSB +: ICX_W];
            end
            if (h_fwd[3]) begin
                fwd_d[h_fwd[2:0]].en = req.wdata[HOOK_EN_BIT];
                fwd_d[h_fwd[2:0]].idx = req.wdata[HOOK_IDX_LSB +: ICX_W];
            end
            // RULE_19: plain storage
            if (h_scr[3])
                scr_d[h_scr[1:0]] = req.wdata;
            // RULE_18: software clears by writing zero
            if (h_flag[3] && !req.wdata[0])
                flag_d[h_flag[2:0]] = 1'b0;
            // RULE_12: direct enable write
            if (req.addr == OFS_IRQ_EN)
                irq_enable_d = req.wdata[7:0];
            // RULE_13: write one to enable
            if (req.addr == OFS_IRQ_SET)
                irq_enable_d = irq_enable_q | req.wdata[7:0];
            // RULE_14: write one to disable
            if (req.addr == OFS_IRQ_CLR)
                irq_enable_d = irq_enable_q & ~req.wdata[7:0];
        end
        // RULE_09 RULE_17: event sets flag; set beats clear
        flag_d = flag_d | recv_ev;
        // RULE_15: level interrupt from pending
        irq_d = |(flag_d & irq_enable_d);
    end

    // Read mux, answered one cycle after the strobe
    always_comb begin
        rdata_d = RST_WORD;
        if (req.rd) begin
            if (h_hook[3])
                rdata_d = hook_word(hook_q[h_hook[2:0]]);
            else if (h_fwd[3])
                rdata_d = hook_word(fwd_q[h_fwd[2:0]]);
            else if (h_flag[3])
                rdata_d = {31'h0, flag_q[h_flag[2:0]]};
            else if (h_smap[3])
                rdata_d = {24'h0, send_map_q[h_smap[2:0]]};
            else if (h_rmap[3])
                rdata_d = {24'h0, recv_map_q[h_rmap[2:0]]};
            else if (h_scr[3])
                rdata_d = scr_q[h_scr[1:0]];
            else if (req.addr == OFS_IRQ_EN || req.addr == OFS_IRQ_SET ||
                     req.addr == OFS_IRQ_CLR)
                rdata_d = {24'h0, irq_enable_q};
            // RULE_15: pending view
            else if (req.addr == OFS_IRQ_PEND)
                rdata_d = {24'h0, flag_q & irq_enable_q};
        end
    end

    // RULE_05: all state is private to this instance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int n = 0; n < NUM_TASKS; n++) begin
                send_map_q[n] <= 8'h00;
                recv_map_q[n] <= 8'h00;
                hook_q[n] <= '0;
                fwd_q[n] <= '0;
            end
            for (int k = 0; k < 4; k++)
                scr_q[k] <= RST_WORD;
            flag_q <= 8'h00;
            irq_enable_q <= 8'h00;
            chan_q <= '0;
            icx_q <= '0;
            rdata_q <= RST_WORD;
            irq_q <= 1'b0;
        end else begin
            send_map_q <= send_map_d;
            recv_map_q <= recv_map_d;
            hook_q <= hook_d;
            fwd_q <= fwd_d;
            scr_q <= scr_d;
            flag_q <= flag_d;
            irq_enable_q <= irq_enable_d;
            chan_q.pulse <= chan_d;
            icx_q <= icx_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign chan_out = chan_q;
    assign icx_out = icx_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

    // Checks
    property p_send_map;
        @(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr == OFS_SEND_TRIG && req.wdata[0] &&
         !hook_q[0].en) |=> ((chan_out.pulse & send_map_q[0]) ==
                              send_map_q[0]);
    endproperty
    a_send_map: assert property (p_send_map) // RULE_01
        else $error("send task 0 missed a mapped channel");

    property p_idle_chan;
        @(posedge core_clk) disable iff (!rst_n)
        (!req.wr && icx_in == '0) |=> chan_out.pulse == '0;
    endproperty
    a_idle_chan: assert property (p_idle_chan) // RULE_06
        else $error("channel pulse with no trigger");

    property p_recv_flag;
        @(posedge core_clk) disable iff (!rst_n)
        |(chan_in.pulse & recv_map_q[2]) |=> flag_q[2];
    endproperty
    a_recv_flag: assert property (p_recv_flag) // RULE_09
        else $error("receive flag 2 not set by pulse");

    property p_flag_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (flag_q[0] && !(req.wr && req.addr == OFS_RECV_FLAG)) |=> flag_q[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) // RULE_17
        else $error("receive flag 0 dropped on its own");

    property p_irq_level;
        @(posedge core_clk) disable iff (!rst_n)
        ##1 irq == |(flag_q & irq_enable_q);
    endproperty
    a_irq_level: assert property (p_irq_level) // RULE_15
        else $error("irq differs from pending");

    property p_en_set;
        @(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr == OFS_IRQ_SET) |=>
            ((irq_enable_q & $past(req.wdata[7:0])) == $past(req.wdata[7:0]));
    endproperty
    a_en_set: assert property (p_en_set) // RULE_13
        else $error("enable-set did not enable");

    property p_en_clr;
        @(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr == OFS_IRQ_CLR) |=>
            ((irq_enable_q & $past(req.wdata[7:0])) == 8'h00);
    endproperty
    a_en_clr: assert property (p_en_clr) // RULE_14
        else $error("enable-clear did not disable");

    property p_pend_read;
        @(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr == OFS_IRQ_PEND) |=>
            reg_rdata == {24'h0, $past(flag_q & irq_enable_q)};
    endproperty
    a_pend_read: assert property (p_pend_read) // RULE_15
        else $error("pending read wrong");

    property p_fwd;
        @(posedge core_clk) disable iff (!rst_n)
        (fwd_q[1].en && |(chan_in.pulse & recv_map_q[1])) |=>
            icx_out[$past(fwd_q[1].idx)];
    endproperty
    a_fwd: assert property (p_fwd) // RULE_11
        else $error("receive event 1 not forwarded");
endmodule
`default_nettype wire

// *** test/pevu_peer.sv ***
/*
 * Peer event unit of another processor on the shared channels.
 * Assumes the bench raises fire right after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pevu_peer
    import pevu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Local unit and bench request
    input wire pevu_pkg::pevu_chan_t own,
    input wire logic fire,
    input wire logic [7:0] mask,
    // Wired-OR channel bus
    output pevu_pkg::pevu_chan_t bus
);
    logic [7:0] peer_d;
    logic [7:0] peer_q;
    always_comb begin
        peer_d = fire ? mask : 8'h00;
    end
    always_ff @(posedge core_clk) begin
        peer_q <= rst_n ? peer_d : 8'h00;
    end
    // No internal loopback, so own pulses join here
    assign bus.pulse = own.pulse | peer_q;
endmodule
`default_nettype wire

// *** test/pevu_top_tb.sv ***
/*
 * Self-checking bench for the processor event unit.
 * Assumes one peer unit sharing the channels and no other masters.
 */
`timescale 1ns/1ps
`default_nettype none
module pevu_top_tb;
    import pevu_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    pevu_chan_t chan_in;
    pevu_chan_t chan_out;
    logic [255:0] icx_in = 256'h0;
    logic [255:0] icx_out;
    logic irq;
    logic fire = 1'b0;
    logic [7:0] mask = 8'h00;
    int fail_count = 0;
    int total_checks = 0;
    always #4 core_clk = ~core_clk;
    pevu_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out),
        .icx_in(icx_in), .icx_out(icx_out), .irq(irq));
    pevu_peer u_peer (.core_clk(core_clk), .rst_n(rst_n), .own(chan_out),
        .fire(fire), .mask(mask), .bus(chan_in));
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic ppulse(input logic [7:0] m);
        @(posedge core_clk);
        fire <= 1'b1;
        mask <= m;
        @(posedge core_clk);
        fire <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic t_reset();
        for (int n = 0; n < 8; n++) begin
            rdchk(OFS_SEND_MAP + 12'(4*n), 32'h0);
            rdchk(OFS_RECV_MAP + 12'(4*n), 32'h0);
            rdchk(OFS_RECV_FLAG + 12'(4*n), 32'h0);
        end
        rdchk(OFS_IRQ_EN, 32'h0);
        wr(12'h7F0, 32'hFFFFFFFF);
        rdchk(12'h7F0, 32'h0);
    endtask
    task automatic t_send();
        logic [7:0] m;
        for (int n = 0; n < 8; n++) begin
            m = (n == 7) ? 8'hFF : 8'h5A ^ 8'(1 << n);
            wr(OFS_SEND_MAP + 12'(4*n), {24'h0, m});
            rdchk(OFS_SEND_MAP + 12'(4*n), {24'h0, m});
            wr(OFS_SEND_TRIG + 12'(4*n), 32'h1);
            #1 chk(chan_out.pulse, m);
            @(posedge core_clk);
            #1 chk(chan_out.pulse, 8'h00);
        end
    endtask
    task automatic t_irq();
        wr(OFS_RECV_MAP + 12'h010, 32'h10);
        ppulse(8'h10);
        rdchk(OFS_RECV_FLAG + 12'h010, 32'h1);
        rdchk(OFS_IRQ_PEND, 32'h0);
        chk(irq, 1'b0);
        wr(OFS_IRQ_SET, 32'h10);
        #1 chk(irq, 1'b1);
        rdchk(OFS_IRQ_PEND, 32'h10);
        wr(OFS_IRQ_CLR, 32'h10);
        #1 chk(irq, 1'b0);
        rdchk(OFS_IRQ_CLR, 32'h0);
        wr(OFS_IRQ_EN, 32'hFF);
        wr(OFS_IRQ_SET, 32'h0);
        rdchk(OFS_IRQ_SET, 32'hFF);
        chk(irq, 1'b1);
        wr(OFS_IRQ_CLR, 32'h01);
        rdchk(OFS_IRQ_EN, 32'hFE);
        wr(OFS_RECV_FLAG + 12'h010, 32'h0);
        #1 chk(irq, 1'b0);
        rdchk(OFS_RECV_FLAG + 12'h010, 32'h0);
    endtask
    task automatic t_recv();
        wr(OFS_RECV_MAP, 32'h0C);
        wr(OFS_RECV_MAP + 12'h01C, 32'hFF);
        wr(OFS_RECV_MAP + 12'h008, 32'h01);
        ppulse(8'h01);
        rdchk(OFS_RECV_FLAG, 32'h0);
        rdchk(OFS_RECV_FLAG + 12'h008, 32'h1);
        rdchk(OFS_RECV_FLAG + 12'h01C, 32'h1);
        ppulse(8'h08);
        rdchk(OFS_RECV_FLAG, 32'h1);
    endtask
    task automatic t_both();
        wr(OFS_SEND_MAP, 32'h04);
        wr(OFS_RECV_MAP + 12'h004, 32'h04);
        wr(OFS_RECV_FWD + 12'h004, 32'h80000003);
        rdchk(OFS_RECV_FWD + 12'h004, 32'h80000003);
        @(posedge core_clk);
        reg_addr <= OFS_SEND_TRIG;
        reg_wdata <= 32'h1;
        reg_wr <= 1'b1;
        fire <= 1'b1;
        mask <= 8'h04;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        fire <= 1'b0;
        @(posedge core_clk);
        #1 chk(icx_out, 256'h8);
        @(posedge core_clk);
        #1 chk(icx_out, 256'h0);
        rdchk(OFS_RECV_FLAG + 12'h004, 32'h1);
    endtask
    task automatic t_hook();
        wr(OFS_SEND_MAP + 12'h008, 32'hA5);
        wr(OFS_SEND_HOOK + 12'h008, 32'h80000005);
        wr(OFS_SEND_MAP + 12'h00C, 32'hFF);
        wr(OFS_SEND_HOOK + 12'h00C, 32'h00000006);
        rdchk(OFS_SEND_HOOK + 12'h008, 32'h80000005);
        @(posedge core_clk);
        icx_in <= 256'h60;
        @(posedge core_clk);
        icx_in <= 256'h0;
        #1 chk(chan_out.pulse, 8'hA5);
        for (int n = 0; n < 4; n++) begin
            wr(OFS_SCRATCH + 12'(4*n), 32'hC0DE0000 + 32'(n));
        end
        for (int n = 0; n < 4; n++) begin
            rdchk(OFS_SCRATCH + 12'(4*n), 32'hC0DE0000 + 32'(n));
        end
    endtask
    // Mid-run reset must drop configured state and a live irq
    task automatic t_rerst();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk(irq, 1'b0);
        rdchk(OFS_SEND_MAP + 12'h008, 32'h0);
        rdchk(OFS_RECV_MAP + 12'h004, 32'h0);
        rdchk(OFS_RECV_FLAG, 32'h0);
        rdchk(OFS_RECV_FWD + 12'h004, 32'h0);
        rdchk(OFS_IRQ_EN, 32'h0);
    endtask
    task automatic results();
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_send();
        t_irq();
        t_recv();
        t_both();
        t_hook();
        t_rerst();
        results();
    end
endmodule
`default_nettype wire
